// >>> difm_top.sv
// digital input function mapper with its register slave and interrupt
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
// Behaviour
// RL1: five selectors 0..16, write only when stopped
// RL2: code 0 only shows input status
// RL3: code 1 closed start, open stop
// RL4: code 2 starts on closing edge
// RL5: code 3 stops on opening edge
// RL6: code 4 enables while closed
// RL7: code 5 open local, closed remote
// RL8: code 7 selects forward or reverse contactor
// RL9: code 8 open raises external fault
// RL10: code 9 open raises external alarm
// RL11: code 10 braking permitted only while closed
// RL12: code 11 closing resets an active fault
// RL13: code 12 close loads set one, open two
// RL14: input three code 14 emergency run
// RL15: code 6 any closed enables jog
// RL16: three-wire start and stop come paired; selector writes do not check the pairing, only the reset values pair them
// RL17: general disable stops at once, no ramp
// RL18: fault reset only on closing edge
// RL19: inputs synchronised and debounced before detection
module difm_top #(
  parameter int DEBOUNCE_CYCLES = difm_pkg::DEBOUNCE_CYCLES
) (
  // clock and control
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  input  wire logic              clk_en,
  // axi4-lite slave
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // field contacts, bit 0 is control_input_one
  input  wire logic [4:0]        control_input,
  // drive state
  input  wire logic              motor_stopped,
  input  wire logic              fault_active,
  // commands and interrupt
  output difm_pkg::difm_cmd_t    cmd,
  output logic                   irq
);
  localparam int N = difm_pkg::NUM_IN;

  generate
    if (N != 5) begin : g_bad_n
      $error("mapper serves exactly five inputs");
    end
  endgenerate

  // reserved codes fall back to unused
  function automatic logic [4:0] eff_code(input int idx, input logic [4:0] code);
    if (code == difm_pkg::FN_EMERG && idx == difm_pkg::EMERG_INPUT) begin
      return code;
    end else if (code > difm_pkg::FN_LAST_STD) begin
      return difm_pkg::FN_UNUSED;
    end else begin
      return code;
    end
  endfunction

  logic [N-1:0][4:0]            fsel_reg;
  logic [difm_pkg::IRQ_W-1:0]   irq_stat_reg;
  logic [difm_pkg::IRQ_W-1:0]   irq_mask_reg;
  logic [N-1:0]                 lvl;
  logic [N-1:0]                 prev_reg;
  logic [N-1:0]                 rise;
  logic [N-1:0]                 fall;
  logic [N-1:0]                 is_run, is_st3, is_sp3, is_gen, is_site, is_jog;
  logic [N-1:0]                 is_dir, is_flt, is_alm, is_brk, is_rst, is_load, is_emg;
  difm_pkg::difm_cmd_t          cmd_next;
  logic [difm_pkg::IRQ_W-1:0]   irq_evt;

  // input conditioning
  for (genvar g = 0; g < N; g++) begin : g_in
    difm_debounce #(
      .CNT_MAX (DEBOUNCE_CYCLES)
    ) u_db (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .clk_en  (clk_en),
      .raw     (control_input[g]),
      .level   (lvl[g])
    );
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      prev_reg <= '0;
    end else if (clk_en) begin
      prev_reg <= lvl;
    end
  end

  assign rise = lvl & ~prev_reg; // RL18
  assign fall = ~lvl & prev_reg;

  // per-input function decode
  always_comb begin
    logic [4:0] c;
    c = '0;
    for (int i = 0; i < N; i++) begin
      c = eff_code(i, fsel_reg[i]);
      is_run[i]  = (c == difm_pkg::FN_START_STOP);
      is_st3[i]  = (c == difm_pkg::FN_START_3W);
      is_sp3[i]  = (c == difm_pkg::FN_STOP_3W);
      is_gen[i]  = (c == difm_pkg::FN_GEN_EN);
      is_site[i] = (c == difm_pkg::FN_SITE);
      is_jog[i]  = (c == difm_pkg::FN_JOG);
      is_dir[i]  = (c == difm_pkg::FN_DIR);
      is_flt[i]  = (c == difm_pkg::FN_NO_FAULT);
      is_alm[i]  = (c == difm_pkg::FN_NO_ALARM);
      is_brk[i]  = (c == difm_pkg::FN_BRAKE);
      is_rst[i]  = (c == difm_pkg::FN_RESET);
      is_load[i] = (c == difm_pkg::FN_LOAD_USER);
      is_emg[i]  = (c == difm_pkg::FN_EMERG); // RL14
    end
  end

  // command mapping; unprogrammed functions keep their neutral value
  always_comb begin
    cmd_next                     = difm_pkg::CMD_RST;
    cmd_next.run_level           = |(lvl & is_run); // RL3
    cmd_next.start_pulse         = |(rise & is_st3); // RL4
    cmd_next.stop_pulse          = |(fall & is_sp3); // RL5
    cmd_next.gen_enable          = &(lvl | ~is_gen); // RL6
    cmd_next.coast_stop          = ~cmd_next.gen_enable; // RL17
    cmd_next.command_site_select = |(lvl & is_site); // RL7
    cmd_next.jog_enable          = |(lvl & is_jog); // RL15
    cmd_next.reverse_contactor   = |(lvl & is_dir); // RL8
    cmd_next.forward_contactor   = ~cmd_next.reverse_contactor; // RL8
    cmd_next.ext_fault           = |(~lvl & is_flt); // RL9
    cmd_next.ext_alarm           = |(~lvl & is_alm); // RL10
    cmd_next.brake_permit        = &(lvl | ~is_brk); // RL11
    cmd_next.fault_reset         = |(rise & is_rst) & fault_active; // RL12
    cmd_next.load_user1          = |(rise & is_load) & motor_stopped; // RL13
    cmd_next.load_user2          = |(fall & is_load) & motor_stopped; // RL13
    cmd_next.emerg_run           = |(lvl & is_emg); // RL14
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cmd <= difm_pkg::CMD_RST;
    end else if (clk_en) begin
      cmd <= cmd_next;
    end
  end

  // interrupt events
  always_comb begin
    irq_evt                            = '0;
    irq_evt[difm_pkg::IRQ_START]       = cmd_next.start_pulse;
    irq_evt[difm_pkg::IRQ_STOP]        = cmd_next.stop_pulse;
    irq_evt[difm_pkg::IRQ_FAULT_RST]   = cmd_next.fault_reset;
    irq_evt[difm_pkg::IRQ_LOAD1]       = cmd_next.load_user1;
    irq_evt[difm_pkg::IRQ_LOAD2]       = cmd_next.load_user2;
    irq_evt[difm_pkg::IRQ_EXT_FAULT]   = cmd_next.ext_fault & ~cmd.ext_fault;
    irq_evt[difm_pkg::IRQ_EXT_ALARM]   = cmd_next.ext_alarm & ~cmd.ext_alarm;
  end

  // register slave
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        wr_fire;
  logic        rd_fire;
  logic        wr_sel_hit;
  logic        wr_ok;
  logic [2:0]  wr_idx;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic        irq_clr;

  assign s_axi_awready = clk_en & ~aw_held_reg;
  assign s_axi_wready  = clk_en & ~w_held_reg;
  assign s_axi_arready = clk_en & ~s_axi_rvalid;
  assign wr_fire       = clk_en & aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign rd_fire       = s_axi_arvalid & s_axi_arready;
  assign wr_idx        = awaddr_reg[4:2];
  assign wr_sel_hit    = (awaddr_reg[1:0] == 2'h0) && (awaddr_reg[7:5] == 3'h0)
                         && (wr_idx < 3'(N));
  // selectors change only while stopped, and only to a defined code
  assign wr_ok = wr_sel_hit && motor_stopped
                 && (wdata_reg <= 32'(difm_pkg::FN_MAX)); // RL1
  assign irq_clr = rd_fire && (s_axi_araddr == difm_pkg::ADDR_IRQSTAT);

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= difm_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_ok || awaddr_reg == difm_pkg::ADDR_IRQMASK)
                        ? difm_pkg::RESP_OKAY : difm_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      fsel_reg[0] <= difm_pkg::FSEL1_RST; // RL1
      fsel_reg[1] <= difm_pkg::FSEL2_RST;
      for (int i = 2; i < N; i++) begin
        fsel_reg[i] <= difm_pkg::FSELX_RST;
      end
    end else if (wr_fire && wr_ok && wstrb_reg[0]) begin
      fsel_reg[wr_idx] <= wdata_reg[4:0]; // RL1
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      irq_mask_reg <= difm_pkg::IRQ_MASK_RST;
    end else if (wr_fire && awaddr_reg == difm_pkg::ADDR_IRQMASK && wstrb_reg[0]) begin
      irq_mask_reg <= wdata_reg[difm_pkg::IRQ_W-1:0];
    end
  end

  // sticky events, read clears, a new event wins over the clear
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      irq_stat_reg <= '0;
    end else if (clk_en) begin
      irq_stat_reg <= (irq_stat_reg & ~{difm_pkg::IRQ_W{irq_clr}}) | irq_evt;
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      difm_pkg::ADDR_INSTAT:  rd_word = 32'(lvl); // RL2
      difm_pkg::ADDR_IRQSTAT: rd_word = 32'(irq_stat_reg);
      difm_pkg::ADDR_IRQMASK: rd_word = 32'(irq_mask_reg);
      difm_pkg::ADDR_CMDSTAT: rd_word = 32'(cmd);
      default: begin
        if (s_axi_araddr[1:0] == 2'h0 && s_axi_araddr[7:5] == 3'h0
            && s_axi_araddr[4:2] < 3'(N)) begin
          rd_word = 32'(fsel_reg[s_axi_araddr[4:2]]);
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= difm_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? difm_pkg::RESP_OKAY : difm_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // checks
  AST_SEL_FROZEN: assert property (@(posedge ref_clk) disable iff (!nrst) // RL1
    !motor_stopped |=> $stable(fsel_reg))
    else $error("selector changed while the motor runs");

  AST_SEL_RANGE: assert property (@(posedge ref_clk) disable iff (!nrst) // RL1
    wr_fire && wr_sel_hit && wdata_reg > 32'(difm_pkg::FN_MAX)
    |=> s_axi_bvalid && s_axi_bresp == difm_pkg::RESP_SLVERR)
    else $error("out of range selector write not refused");

  AST_UNUSED_QUIET: assert property (@(posedge ref_clk) disable iff (!nrst) // RL2
    clk_en && fsel_reg == '0 |=> !cmd.start_pulse && !cmd.stop_pulse
    && !cmd.run_level && cmd.gen_enable && !cmd.fault_reset && !cmd.ext_fault)
    else $error("unused inputs produced a command");

  AST_RUN_LEVEL: assert property (@(posedge ref_clk) disable iff (!nrst) // RL3
    clk_en |=> cmd.run_level == $past(|(lvl & is_run)))
    else $error("level start request mismatch");

  AST_START_EDGE: assert property (@(posedge ref_clk) disable iff (!nrst) // RL4
    clk_en && lvl[0] && !prev_reg[0] && fsel_reg[0] == 5'h02 |=> cmd.start_pulse)
    else $error("closing edge on a start input gave no start");

  AST_STOP_EDGE: assert property (@(posedge ref_clk) disable iff (!nrst) // RL5
    clk_en && !lvl[1] && prev_reg[1] && fsel_reg[1] == 5'h03 |=> cmd.stop_pulse)
    else $error("opening edge on a stop input gave no stop");

  AST_COAST: assert property (@(posedge ref_clk) disable iff (!nrst) // RL17
    clk_en && |(~lvl & is_gen) |=> cmd.coast_stop && !cmd.gen_enable)
    else $error("general disable without immediate stop");

  AST_GEN_EN: assert property (@(posedge ref_clk) disable iff (!nrst) // RL6
    clk_en && |(~lvl & is_gen) |=> !cmd.gen_enable)
    else $error("open enable input left drive enabled");

  AST_SITE: assert property (@(posedge ref_clk) disable iff (!nrst) // RL7
    clk_en |=> cmd.command_site_select == $past(|(lvl & is_site)))
    else $error("command site mismatch");

  AST_DIR: assert property (@(posedge ref_clk) disable iff (!nrst) // RL8
    clk_en |=> cmd.reverse_contactor == $past(|(lvl & is_dir))
    && cmd.forward_contactor != cmd.reverse_contactor)
    else $error("contactors not exclusive");

  AST_EXT_FAULT: assert property (@(posedge ref_clk) disable iff (!nrst) // RL9
    clk_en |=> cmd.ext_fault == $past(|(~lvl & is_flt)))
    else $error("external fault mismatch");

  AST_EXT_ALARM: assert property (@(posedge ref_clk) disable iff (!nrst) // RL10
    clk_en |=> cmd.ext_alarm == $past(|(~lvl & is_alm)))
    else $error("external alarm mismatch");

  AST_BRAKE: assert property (@(posedge ref_clk) disable iff (!nrst) // RL11
    clk_en && |(~lvl & is_brk) |=> !cmd.brake_permit)
    else $error("braking permitted with an open brake input");

  AST_FAULT_RESET: assert property (@(posedge ref_clk) disable iff (!nrst) // RL12
    $rose(cmd.fault_reset) |-> $past(fault_active) && $past(|(rise & is_rst)))
    else $error("fault reset without active fault and closing edge");

  AST_RESET_ONCE: assert property (@(posedge ref_clk) disable iff (!nrst) // RL18
    clk_en && |(lvl & prev_reg & is_rst) && !(|(rise & is_rst)) |=> !cmd.fault_reset)
    else $error("held reset input repeated the reset");

  AST_LOAD: assert property (@(posedge ref_clk) disable iff (!nrst) // RL13
    $rose(cmd.load_user1) || $rose(cmd.load_user2) |-> $past(motor_stopped))
    else $error("user set loaded while the motor runs");

  AST_EMERG: assert property (@(posedge ref_clk) disable iff (!nrst) // RL14
    clk_en |=> cmd.emerg_run == $past(lvl[2] && fsel_reg[2] == 5'h0E))
    else $error("emergency run not tied to input three");

  AST_JOG: assert property (@(posedge ref_clk) disable iff (!nrst) // RL15
    clk_en && |(lvl & is_jog) |=> cmd.jog_enable)
    else $error("closed jog input did not enable jog");

endmodule // difm_top

// >>> difm_pkg.sv
// constants, codes, register map and command carrier of the input function mapper
package difm_pkg;

  localparam int NUM_IN      = 5;
  localparam int FSEL_W      = 5;
  localparam int EMERG_INPUT = 2;

  // function codes
  localparam logic [4:0] FN_UNUSED    = 5'h00;
  localparam logic [4:0] FN_START_STOP = 5'h01;
  localparam logic [4:0] FN_START_3W  = 5'h02;
  localparam logic [4:0] FN_STOP_3W   = 5'h03;
  localparam logic [4:0] FN_GEN_EN    = 5'h04;
  localparam logic [4:0] FN_SITE      = 5'h05;
  localparam logic [4:0] FN_JOG       = 5'h06;
  localparam logic [4:0] FN_DIR       = 5'h07;
  localparam logic [4:0] FN_NO_FAULT  = 5'h08;
  localparam logic [4:0] FN_NO_ALARM  = 5'h09;
  localparam logic [4:0] FN_BRAKE     = 5'h0A;
  localparam logic [4:0] FN_RESET     = 5'h0B;
  localparam logic [4:0] FN_LOAD_USER = 5'h0C;
  localparam logic [4:0] FN_EMERG     = 5'h0E;
  localparam logic [4:0] FN_LAST_STD  = 5'h0C;
  localparam logic [4:0] FN_MAX       = 5'h10;

  // reset values of the selectors
  localparam logic [4:0] FSEL1_RST  = 5'h02;
  localparam logic [4:0] FSEL2_RST  = 5'h03;
  localparam logic [4:0] FSELX_RST  = 5'h00;

  // register byte addresses
  localparam logic [7:0] ADDR_FSEL0   = 8'h00;
  localparam logic [7:0] ADDR_INSTAT  = 8'h14;
  localparam logic [7:0] ADDR_IRQSTAT = 8'h18;
  localparam logic [7:0] ADDR_IRQMASK = 8'h1C;
  localparam logic [7:0] ADDR_CMDSTAT = 8'h20;

  // interrupt status bits
  localparam int IRQ_W          = 7;
  localparam int IRQ_START      = 0;
  localparam int IRQ_STOP       = 1;
  localparam int IRQ_FAULT_RST  = 2;
  localparam int IRQ_LOAD1      = 3;
  localparam int IRQ_LOAD2      = 4;
  localparam int IRQ_EXT_FAULT  = 5;
  localparam int IRQ_EXT_ALARM  = 6;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 7'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // debounce time and its cycle count
  localparam int CLK_FREQ_MHZ     = 100;
  localparam int DEBOUNCE_TIME_US = 10000;
  localparam int DEBOUNCE_CYCLES  = DEBOUNCE_TIME_US * CLK_FREQ_MHZ;

  typedef struct packed {
    logic run_level;
    logic start_pulse;
    logic stop_pulse;
    logic gen_enable;
    logic coast_stop;
    logic command_site_select;
    logic jog_enable;
    logic forward_contactor;
    logic reverse_contactor;
    logic ext_fault;
    logic ext_alarm;
    logic brake_permit;
    logic fault_reset;
    logic load_user1;
    logic load_user2;
    logic emerg_run;
  } difm_cmd_t;

  localparam difm_cmd_t CMD_RST = 16'h1110;

endpackage

// >>> difm_debounce.sv
// two-flop synchroniser and stability filter for one contact input
`timescale 1ns/1ns
module difm_debounce #(
  parameter int CNT_MAX = difm_pkg::DEBOUNCE_CYCLES
) (
  // clock and control
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic clk_en,
  // contact
  input  wire logic raw,
  output logic      level
);
  localparam int CW = $clog2(CNT_MAX + 1);

  generate
    if (CNT_MAX < 1) begin : g_bad
      $error("debounce count must be at least one");
    end
  endgenerate

  logic          sync1_reg;
  logic          sync2_reg;
  logic [CW-1:0] cnt_reg;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else if (clk_en) begin
      sync1_reg <= raw;
      sync2_reg <= sync1_reg;
    end
  end

  // level follows only after it held for the full count
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cnt_reg <= '0;
      level   <= 1'b0;
    end else if (clk_en) begin
      if (sync2_reg == level) begin
        cnt_reg <= '0;
      end else if (cnt_reg == CW'(CNT_MAX - 1)) begin
        cnt_reg <= '0;
        level   <= sync2_reg; // RL19
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  AST_DEBOUNCE_HOLD: assert property (@(posedge ref_clk) disable iff (!nrst) // RL19
    $changed(level) |-> $past(cnt_reg) == CW'(CNT_MAX - 1) && $past(clk_en))
    else $error("debounced level changed before the count ran out");

endmodule // difm_debounce

// >>> difm_contacts.sv
// field contact model: switches and pushbuttons with short contact bounce
`timescale 1ns/1ns
module difm_contacts (
  // clock
  input  wire logic       ref_clk,
  // wanted contact states, 1 = closed
  input  wire logic [4:0] target,
  // contact levels seen by the block
  output logic      [4:0] control_input
);
  logic [4:0] settled = 5'h00;
  logic [1:0] bnc [5] = '{default: 2'h0};

  always @(posedge ref_clk) begin
    for (int i = 0; i < 5; i++) begin
      if (target[i] !== settled[i]) begin
        settled[i] <= target[i];
        bnc[i]     <= 2'h3;
      end else if (bnc[i] != 2'h0) begin
        bnc[i] <= bnc[i] - 2'h1;
      end
    end
  end

  // one-cycle glitches, shorter than the debounce span
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      control_input[i] = (bnc[i] != 2'h0) ? (settled[i] ^ bnc[i][0]) : settled[i];
    end
  end
endmodule // difm_contacts

// >>> digital_input_function_mapper_tb_top.sv
// self-checking bench of the input function mapper
`timescale 1ns/1ns
module digital_input_function_mapper_tb_top;
  typedef struct {
    logic [4:0]  code;
    logic [15:0] on_v;
    logic [15:0] off_v;
  } difm_row_t;

  logic ref_clk, nrst, clk_en, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, motor_stopped, fault_active, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [4:0] tgt, ci;
  difm_pkg::difm_cmd_t cmd;
  int fails = 0;
  int tests_run = 0;
  int pc [16] = '{default: 0};
  int p;
  difm_row_t rows [13] = '{
    '{5'h00, 16'h1110, 16'h1110}, '{5'h01, 16'h9110, 16'h1110},
    '{5'h04, 16'h1110, 16'h0910}, '{5'h05, 16'h1510, 16'h1110},
    '{5'h06, 16'h1310, 16'h1110}, '{5'h07, 16'h1090, 16'h1110},
    '{5'h08, 16'h1110, 16'h1150}, '{5'h09, 16'h1110, 16'h1130},
    '{5'h0A, 16'h1110, 16'h1100}, '{5'h0D, 16'h1110, 16'h1110},
    '{5'h0E, 16'h1110, 16'h1110}, '{5'h0F, 16'h1110, 16'h1110},
    '{5'h10, 16'h1110, 16'h1110}};

  difm_contacts contacts_u (.ref_clk(ref_clk), .target(tgt), .control_input(ci));

  difm_top #(.DEBOUNCE_CYCLES(4)) dut_u (
    .ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .control_input(ci), .motor_stopped(motor_stopped), .fault_active(fault_active),
    .cmd(cmd), .irq(irq));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // counts cycles in which each command bit is high
  always @(posedge ref_clk) begin
    for (int i = 0; i < 16; i++) begin
      if (cmd[i] === 1'b1) pc[i] <= pc[i] + 1;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1'b1; wvalid <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge ref_clk);
      if (!ad && awready === 1'b1) begin ad = 1'b1; awvalid <= 1'b0; end
      if (!dd && wready === 1'b1) begin dd = 1'b1; wvalid <= 1'b0; end
    end
    do @(posedge ref_clk); while (bvalid !== 1'b1);
    rs = bresp;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    araddr <= a; arvalid <= 1'b1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (rvalid !== 1'b1);
    d = rdata;
    rs = rresp;
  endtask

  task automatic settle;
    repeat (20) @(posedge ref_clk);
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #100000;
    fails++;
    print_verdict;
  end

  initial begin
    nrst = 1'b0; clk_en = 1'b1; tgt = 5'h00; motor_stopped = 1'b1; fault_active = 1'b0;
    awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'h0; wvalid = 1'b0;
    bready = 1'b1; araddr = 8'h00; arvalid = 1'b0; rready = 1'b1;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    chk(cmd, 32'h1110);
    chk(irq, 32'h0);
    for (int i = 0; i < 5; i++) begin
      rd(8'(4 * i), v, r);
      chk(v, (i == 0) ? 32'h2 : (i == 1) ? 32'h3 : 32'h0);
    end
    $display("reset values done");
    // start and stop edges on the default selectors, with an interrupt
    rd(difm_pkg::ADDR_IRQSTAT, v, r);
    p = pc[14];
    tgt <= 5'h01;
    settle;
    chk(32'(pc[14] - p), 32'h1);
    chk(irq, 32'h0);
    wr(difm_pkg::ADDR_IRQMASK, 32'h1, r);
    chk(irq, 32'h1);
    rd(difm_pkg::ADDR_IRQSTAT, v, r);
    chk(v & 32'h1, 32'h1);
    @(posedge ref_clk);
    chk(irq, 32'h0);
    tgt <= 5'h02;
    settle;
    p = pc[13];
    tgt <= 5'h00;
    settle;
    chk(32'(pc[13] - p), 32'h1);
    $display("edge commands done");
    // level functions on input four
    foreach (rows[k]) begin
      wr(8'h0C, 32'(rows[k].code), r);
      settle;
      tgt <= 5'h08;
      settle;
      chk(cmd, rows[k].on_v);
      rd(difm_pkg::ADDR_INSTAT, v, r);
      chk(v, 32'h8);
      tgt <= 5'h00;
      settle;
      chk(cmd, rows[k].off_v);
    end
    $display("level functions done");
    // jog programmed on inputs four and five, only input five closed
    wr(8'h10, 32'h6, r);
    wr(8'h0C, 32'h6, r);
    tgt <= 5'h10;
    settle;
    chk(cmd, 32'h1310);
    tgt <= 5'h00;
    $display("jog done");
    // fault reset only with an active fault, once per closing
    wr(8'h0C, 32'hB, r);
    settle;
    p = pc[3];
    tgt <= 5'h08;
    settle;
    tgt <= 5'h00;
    fault_active <= 1'b1;
    settle;
    chk(32'(pc[3] - p), 32'h0);
    tgt <= 5'h08;
    settle;
    settle;
    chk(32'(pc[3] - p), 32'h1);
    tgt <= 5'h00;
    fault_active <= 1'b0;
    $display("fault reset done");
    // user sets
    wr(8'h0C, 32'hC, r);
    settle;
    p = pc[2];
    tgt <= 5'h08;
    settle;
    chk(32'(pc[2] - p), 32'h1);
    p = pc[1];
    tgt <= 5'h00;
    settle;
    chk(32'(pc[1] - p), 32'h1);
    motor_stopped <= 1'b0;
    p = pc[2];
    tgt <= 5'h08;
    settle;
    chk(32'(pc[2] - p), 32'h0);
    tgt <= 5'h00;
    motor_stopped <= 1'b1;
    $display("user sets done");
    // emergency run on input three
    wr(8'h08, 32'hE, r);
    tgt <= 5'h04;
    settle;
    chk(cmd, 32'h1111);
    tgt <= 5'h00;
    settle;
    chk(cmd, 32'h1110);
    $display("emergency run done");
    // clock enable low freezes the block
    clk_en <= 1'b0;
    tgt <= 5'h10;
    settle;
    chk(cmd, 32'h1110);
    chk({awready, wready, arready}, 32'h0);
    clk_en <= 1'b1;
    settle;
    chk(cmd, 32'h1310);
    tgt <= 5'h00;
    $display("clock enable done");
    // refused writes and reads
    motor_stopped <= 1'b0;
    wr(8'h00, 32'h1, r);
    chk(r, difm_pkg::RESP_SLVERR);
    motor_stopped <= 1'b1;
    wr(8'h00, 32'h11, r);
    chk(r, difm_pkg::RESP_SLVERR);
    rd(8'h00, v, r);
    chk(v, 32'h2);
    wr(8'h24, 32'h1, r);
    chk(r, difm_pkg::RESP_SLVERR);
    rd(8'h24, v, r);
    chk(r, difm_pkg::RESP_SLVERR);
    $display("refusals done");
    // all inputs unused: closed contacts give no command
    for (int i = 0; i < 5; i++) begin
      wr(8'(4 * i), 32'h0, r);
    end
    tgt <= 5'h1F;
    settle;
    chk(cmd, 32'h1110);
    rd(difm_pkg::ADDR_INSTAT, v, r);
    chk(v, 32'h1F);
    $display("unused inputs done");
    // reset in mid-run restores the defaults
    tgt <= 5'h00;
    nrst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    chk(cmd, 32'h1110);
    rd(8'h04, v, r);
    chk(v, 32'h3);
    $display("mid-run reset done");
    print_verdict;
  end
endmodule // digital_input_function_mapper_tb_top
